// >>> shared/charger_supervisor_defines.vh
// Constants for the charger fault supervisor: status codes, timer counts
// and clock switchover figures. Definitions only; included by bare name.
`ifndef CHARGER_SUPERVISOR_DEFINES_VH
`define CHARGER_SUPERVISOR_DEFINES_VH

// Status pair codes {status_out_b, status_out_a}, 1 = released
`define CODE_OFF        2'b11
`define CODE_CHARGING   2'b10
`define CODE_FLOAT      2'b00
`define CODE_FAULT      2'b01

// Absorption timer length in timer oscillator cycles
`define ABS_TIMER_CYCLES 32'h001f_ffff
// Precharge timeout is one eighth of the absorption timeout
`define PCHG_SHIFT       3

// External clock confirmation window, internal oscillator cycles
`define SYNC_CONFIRM_CYCLES 112
// Allowed external clock window, percent of nominal
`define SYNC_TOL_PCT        10
// Halt lengths in switching periods
`define HALT_TO_EXT_PERIODS 2
`define HALT_TO_INT_PERIODS 10

`endif

// >>> rtl/charger_fault_supervisor.v
// Charger state sequencing, fault latching and status pin encoding.
// Analog comparisons arrive as synchronous one-bit inputs; oscillator ticks
// arrive as one-cycle enable pulses on clk_i.
`timescale 1ns/10ps
`include "charger_supervisor_defines.vh"

module charger_fault_supervisor #(
  parameter TIMER_W    = 32,
  parameter ABS_CYCLES = `ABS_TIMER_CYCLES,
  parameter CNT_W      = 8
) (
  input  wire       clk_i,
  input  wire       arst_n_i,
  input  wire       charge_enable_i,
  input  wire       powerup_check_done_i,
  input  wire       freq_set_short_i,
  input  wire       gate_input_short_i,
  input  wire       timer_cap_fault_i,
  input  wire       ref_short_i,
  input  wire       ref_in_window_i,
  input  wire       gate_good_i,
  input  wire       feedback_low_i,
  input  wire       timer_disabled_i,
  input  wire       timer_tick_i,
  input  wire       deep_discharge_above_i,
  input  wire       deep_discharge_ok_i,
  input  wire       cv_reached_i,
  input  wire       taper_reached_i,
  input  wire       temp_low_i,
  input  wire       temp_high_i,
  input  wire       ext_supply_above_high_i,
  input  wire       ext_supply_below_low_i,
  input  wire       int_osc_tick_i,
  input  wire       ext_clk_rise_i,
  input  wire       ext_clk_in_window_i,
  input  wire       sw_period_start_i,
  input  wire       peak_current_over_i,
  input  wire       junction_over_160_i,
  input  wire       junction_cooled_i,
  output wire       status_out_a_o,
  output wire       status_out_a_oe_o,
  output wire       status_out_b_o,
  output wire       status_out_b_oe_o,
  output wire       input_protect_gate_o,
  output wire       high_side_gate_o,
  output wire       switching_enable_o,
  output reg        use_ext_clock_o,
  output reg        external_regulator_o,
  output wire       internal_regulator_o,
  output reg        thermal_shutdown_o,
  output reg        faulty_battery_o,
  output wire       charge_suspended_o,
  output reg  [2:0] charge_state_o
);

  // One-hot charger states
  localparam [5:0] ST_OFF   = 6'h01;
  localparam [5:0] ST_PCHG  = 6'h02;
  localparam [5:0] ST_CC    = 6'h04;
  localparam [5:0] ST_ABS   = 6'h08;
  localparam [5:0] ST_FLOAT = 6'h10;
  localparam [5:0] ST_FAULT = 6'h20;

  // One-hot clock source states
  localparam [2:0] CK_INT  = 3'h1;
  localparam [2:0] CK_HALT = 3'h2;
  localparam [2:0] CK_EXT  = 3'h4;

  localparam [TIMER_W-1:0] ABS_LIMIT  = ABS_CYCLES;
  localparam [TIMER_W-1:0] PCHG_LIMIT = ABS_LIMIT >> `PCHG_SHIFT;
  localparam [CNT_W-1:0] SYNC_N    = `SYNC_CONFIRM_CYCLES;
  localparam [CNT_W-1:0] HALT_EXT  = `HALT_TO_EXT_PERIODS;
  localparam [CNT_W-1:0] HALT_INT  = `HALT_TO_INT_PERIODS;
  localparam [CNT_W-1:0] ONE       = 1;

  reg  [5:0]         state;
  reg  [5:0]         next_state;
  reg  [TIMER_W-1:0] timer;
  reg                suspended;
  reg                powerup_seen;
  reg                timer_reset;
  reg  [2:0]         ck_state;
  reg  [CNT_W-1:0]   osc_cnt;
  reg  [CNT_W-1:0]   halt_cnt;
  reg                ext_seen;
  reg                halt_to_ext;
  reg                ext_confirmed;
  reg                over_cycle;

  wire temp_bad = temp_low_i | temp_high_i;
  wire charging = |(state & (ST_PCHG | ST_CC | ST_ABS | ST_FLOAT));
  wire boot_fault = freq_set_short_i | gate_input_short_i |
                    timer_cap_fault_i | ref_short_i;
  wire run_fault  = ~ref_in_window_i | ~gate_good_i;
  wire dd_fault   = deep_discharge_ok_i == 1'b0 &&
                    (state == ST_ABS || state == ST_FLOAT);
  wire pchg_tmo   = state == ST_PCHG && !timer_disabled_i &&
                    timer > PCHG_LIMIT;
  wire abs_tmo    = !timer_disabled_i && timer > ABS_LIMIT;
  wire any_fault  = (!powerup_seen && powerup_check_done_i && boot_fault) |
                    (powerup_seen && (run_fault | feedback_low_i)) |
                    pchg_tmo | dd_fault;

  // Charger state decision
  always @* begin
    next_state  = state;
    timer_reset = 1'b0;
    case (state)
      ST_OFF: begin
        if (powerup_check_done_i && boot_fault)
          next_state = ST_FAULT;
        else if (powerup_check_done_i && charge_enable_i)
          next_state = ST_PCHG;
      end
      ST_PCHG: begin
        if (any_fault)
          next_state = ST_FAULT;
        else if (!suspended && deep_discharge_above_i) begin
          next_state  = ST_CC;
          timer_reset = 1'b1;
        end
      end
      ST_CC: begin
        if (any_fault)
          next_state = ST_FAULT;
        else if (!suspended && cv_reached_i)
          next_state = ST_ABS;
      end
      ST_ABS: begin
        if (any_fault)
          next_state = ST_FAULT;
        else if (!suspended && (taper_reached_i || abs_tmo)) begin
          next_state  = ST_FLOAT;
          timer_reset = 1'b1;
        end
      end
      ST_FLOAT: begin
        if (any_fault)
          next_state = ST_FAULT;
      end
      ST_FAULT: next_state = ST_FAULT;
      default:  next_state = ST_FAULT;
    endcase
  end

  // State, suspend flag and charge timer
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state        <= ST_OFF;
      suspended    <= 1'b0;
      timer        <= {TIMER_W{1'b0}};
      powerup_seen <= 1'b0;
    end else begin
      state <= next_state;
      if (powerup_check_done_i)
        powerup_seen <= 1'b1;
      // Suspend tracks temperature; prior state is kept
      suspended <= charging && next_state != ST_FAULT && temp_bad;
      if (timer_reset || next_state == ST_FAULT)
        timer <= {TIMER_W{1'b0}};
      else if (timer_tick_i && !temp_bad && !suspended &&
               (state == ST_PCHG || state == ST_ABS))
        timer <= timer + 1'b1;
    end
  end

  // Status pins: oe high pulls the open-drain pin low
  assign status_out_a_oe_o = charging & ~suspended;
  assign status_out_b_oe_o = (state == ST_FLOAT && !suspended) |
                             state == ST_FAULT | suspended;
  assign status_out_a_o    = 1'b0;
  assign status_out_b_o    = 1'b0;
  assign charge_suspended_o = suspended;

  // Coded state for observation
  always @* begin
    case (state)
      ST_OFF:   charge_state_o = 3'h0;
      ST_PCHG:  charge_state_o = 3'h1;
      ST_CC:    charge_state_o = 3'h2;
      ST_ABS:   charge_state_o = 3'h3;
      ST_FLOAT: charge_state_o = 3'h4;
      default:  charge_state_o = 3'h5;
    endcase
  end

  // Faulty battery flag, held with the latched fault
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      faulty_battery_o <= 1'b0;
    else if (pchg_tmo && state == ST_PCHG)
      faulty_battery_o <= 1'b1;
  end

  // Regulator select with hysteresis
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      external_regulator_o <= 1'b0;
    else if (ext_supply_above_high_i)
      external_regulator_o <= 1'b1;
    else if (ext_supply_below_low_i)
      external_regulator_o <= 1'b0;
  end
  assign internal_regulator_o = ~external_regulator_o;

  // Thermal shutdown with automatic restart
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      thermal_shutdown_o <= 1'b0;
    else if (junction_over_160_i)
      thermal_shutdown_o <= 1'b1;
    else if (junction_cooled_i)
      thermal_shutdown_o <= 1'b0;
  end

  // External clock confirmation over internal oscillator cycles
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_cnt       <= {CNT_W{1'b0}};
      ext_seen      <= 1'b1;
      ext_confirmed <= 1'b0;
    end else if (int_osc_tick_i) begin
      if (osc_cnt == SYNC_N - ONE) begin
        osc_cnt       <= {CNT_W{1'b0}};
        ext_confirmed <= ext_seen | ext_clk_rise_i;
        ext_seen      <= 1'b1;
      end else begin
        osc_cnt  <= osc_cnt + ONE;
        ext_seen <= ext_seen & ext_clk_rise_i;
      end
    end else if (!ext_clk_rise_i && osc_cnt == {CNT_W{1'b0}}) begin
      ext_seen <= ext_seen;
    end
  end

  // Clock source switchover with halt periods
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ck_state    <= CK_INT;
      halt_cnt    <= {CNT_W{1'b0}};
      halt_to_ext <= 1'b0;
      use_ext_clock_o <= 1'b0;
    end else begin
      case (ck_state)
        CK_INT: begin
          if (ext_confirmed && ext_clk_in_window_i) begin
            ck_state    <= CK_HALT;
            halt_cnt    <= HALT_EXT;
            halt_to_ext <= 1'b1;
          end
        end
        CK_EXT: begin
          if (!ext_confirmed || !ext_clk_in_window_i) begin
            ck_state        <= CK_HALT;
            halt_cnt        <= HALT_INT;
            halt_to_ext     <= 1'b0;
            use_ext_clock_o <= 1'b0;
          end
        end
        CK_HALT: begin
          if (sw_period_start_i) begin
            if (halt_cnt == ONE) begin
              ck_state        <= halt_to_ext ? CK_EXT : CK_INT;
              use_ext_clock_o <= halt_to_ext;
            end
            halt_cnt <= halt_cnt - ONE;
          end
        end
        default: ck_state <= CK_INT;
      endcase
    end
  end

  // Per-cycle overcurrent, cleared each switching period
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      over_cycle <= 1'b0;
    else if (sw_period_start_i)
      over_cycle <= 1'b0;
    else if (peak_current_over_i)
      over_cycle <= 1'b1;
  end

  // Switching permitted only when charging and not halted
  assign switching_enable_o = charging & ~suspended & ~thermal_shutdown_o &
                              ck_state != CK_HALT;
  assign high_side_gate_o   = switching_enable_o & ~over_cycle &
                              ~peak_current_over_i;
  assign input_protect_gate_o = state != ST_FAULT &&
                                !thermal_shutdown_o;

endmodule

// >>> tb/charger_fault_supervisor_props.sv
// Port checker for the charger fault supervisor.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/10ps
module charger_fault_supervisor_props (
  input wire       clk_i,
  input wire       arst_n_i,
  input wire       feedback_low_i,
  input wire       ext_supply_above_high_i,
  input wire       status_out_a_oe_o,
  input wire       status_out_b_oe_o,
  input wire       input_protect_gate_o,
  input wire       switching_enable_o,
  input wire       external_regulator_o,
  input wire       internal_regulator_o,
  input wire       charge_suspended_o,
  input wire [2:0] charge_state_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Charging states other than float
  wire chg = charge_state_o != 3'h0 && charge_state_o < 3'h4;

  a_off_code: assert property (charge_state_o == 3'h0 |->
    !status_out_a_oe_o && !status_out_b_oe_o) else $error("off code");
  a_chg_code: assert property (chg && !charge_suspended_o |->
    status_out_a_oe_o && !status_out_b_oe_o) else $error("charge code");
  a_float_code: assert property (charge_state_o == 3'h4 &&
    !charge_suspended_o |-> status_out_a_oe_o && status_out_b_oe_o)
    else $error("float code");
  a_fault_code: assert property (charge_state_o == 3'h5 ||
    charge_suspended_o |-> !status_out_a_oe_o && status_out_b_oe_o)
    else $error("fault code");
  a_fault_sticky: assert property (charge_state_o == 3'h5 |=>
    $stable(charge_state_o)) else $error("fault left");
  a_fault_off: assert property (charge_state_o == 3'h5 |->
    !input_protect_gate_o && !switching_enable_o) else $error("fault on");
  a_reg_one: assert property (internal_regulator_o !=
    external_regulator_o) else $error("regulators");
  a_ext_reg: assert property (ext_supply_above_high_i |=>
    external_regulator_o) else $error("ext regulator");
  a_fb_latch: assert property ((chg || charge_state_o == 3'h4) &&
    feedback_low_i |=> charge_state_o == 3'h5) else $error("fb latch");
endmodule

bind charger_fault_supervisor charger_fault_supervisor_props i_props (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .feedback_low_i(feedback_low_i),
  .ext_supply_above_high_i(ext_supply_above_high_i),
  .status_out_a_oe_o(status_out_a_oe_o),
  .status_out_b_oe_o(status_out_b_oe_o),
  .input_protect_gate_o(input_protect_gate_o),
  .switching_enable_o(switching_enable_o),
  .external_regulator_o(external_regulator_o),
  .internal_regulator_o(internal_regulator_o),
  .charge_suspended_o(charge_suspended_o), .charge_state_o(charge_state_o));

// >>> tb/charger_partner_model.sv
// Far side: timer and switching oscillators, status monitor.
// Assumes pull-ups on both status pins at the monitor.
`timescale 1ns/10ps
module charger_partner_model (
  input  wire       clk_i,
  input  wire       arst_n_i,
  input  wire       tick_en_i,
  input  wire       a_oe_i,
  input  wire       b_oe_i,
  output wire       timer_tick_o,
  output wire       osc_tick_o,
  output wire       sw_start_o,
  output wire [1:0] pair_o
);
  reg [3:0] count;
  // Free running divider for the oscillators
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      count <= 4'h0;
    else
      count <= count + 4'h1;
  end
  assign osc_tick_o = count[1:0] == 2'h3;
  assign sw_start_o = count[1:0] == 2'h0;
  assign timer_tick_o = tick_en_i && count == 4'hf;
  // Released pin reads 1 through its pull-up
  assign pair_o = {~b_oe_i, ~a_oe_i};
endmodule

// >>> tb/test_charger_fault_supervisor.sv
// Bench for the charger fault supervisor with the far-side model.
// Assumes a 4 ns clock and a shortened absorption count.
`timescale 1ns/10ps
`include "charger_supervisor_defines.vh"
module test_charger_fault_supervisor;
  reg          c, rn, te, en, dn, s0, s1, s2, s3, rw, gg, fb, da, dk, cv, tp;
  reg          tl, th, eh, el, jo, jc;
  wire         tt, ot, ss, ao, bo, gt, su, er, fbat, tsd, sw;
  wire [1:0]   pair;
  wire [2:0]   st;
  integer      bad_count, checks_done, i;
  charger_fault_supervisor #(.ABS_CYCLES(64)) i_dut (
    .clk_i(c), .arst_n_i(rn), .charge_enable_i(en),
    .powerup_check_done_i(dn), .freq_set_short_i(s0),
    .gate_input_short_i(s1), .timer_cap_fault_i(s2), .ref_short_i(s3),
    .ref_in_window_i(rw), .gate_good_i(gg), .feedback_low_i(fb),
    .timer_disabled_i(1'b0), .timer_tick_i(tt), .deep_discharge_above_i(da),
    .deep_discharge_ok_i(dk), .cv_reached_i(cv), .taper_reached_i(tp),
    .temp_low_i(tl), .temp_high_i(th), .ext_supply_above_high_i(eh),
    .ext_supply_below_low_i(el), .int_osc_tick_i(ot), .ext_clk_rise_i(1'b0),
    .ext_clk_in_window_i(1'b0), .sw_period_start_i(ss),
    .peak_current_over_i(1'b0), .junction_over_160_i(jo),
    .junction_cooled_i(jc), .status_out_a_o(), .status_out_a_oe_o(ao),
    .status_out_b_o(), .status_out_b_oe_o(bo), .input_protect_gate_o(gt),
    .high_side_gate_o(), .switching_enable_o(sw), .use_ext_clock_o(),
    .external_regulator_o(er), .internal_regulator_o(),
    .thermal_shutdown_o(tsd), .faulty_battery_o(fbat),
    .charge_suspended_o(su), .charge_state_o(st));
  charger_partner_model i_far (.clk_i(c), .arst_n_i(rn), .tick_en_i(te),
    .a_oe_i(ao), .b_oe_i(bo), .timer_tick_o(tt), .osc_tick_o(ot),
    .sw_start_o(ss), .pair_o(pair));
  // Clock source
  initial begin
    c = 0;
    forever #2 c = ~c;
  end
  task check(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge c);
      #1;
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Bounded wait for a charger state
  task wait_st(input [2:0] s);
    integer k;
    begin
      for (k = 0; st !== s && k < 400; k = k + 1)
        cyc(1);
      if (st !== s) begin
        bad_count = bad_count + 1;
        end_of_test;
      end
    end
  endtask
  task power_up;
    begin
      rn = 0;
      {te, en, dn, s0, s1, s2, s3, fb, da, cv, tp, tl, th, eh, el} = 0;
      {jo, jc} = 2'h0;
      {rw, gg, dk} = 3'h7;
      cyc(3);
      rn = 1;
      cyc(1);
      check(pair, `CODE_OFF);
      dn = 1;
      cyc(1);
      en = 1;
    end
  endtask
  task go_float;
    begin
      wait_st(3'h1);
      check(pair, `CODE_CHARGING);
      da = 1;
      wait_st(3'h2);
      cv = 1;
      wait_st(3'h3);
      tp = 1;
      wait_st(3'h4);
      check(pair, `CODE_FLOAT);
    end
  endtask
  task t_temp;
    begin
      power_up;
      go_float;
      th = 1;
      cyc(2);
      check(su, 1'b1);
      check(pair, `CODE_FAULT);
      th = 0;
      cyc(3);
      check(st, 3'h4);
      $display("temperature test done");
    end
  endtask
  // Thermal shutdown stops switching, cooling restarts it
  task t_therm;
    begin
      power_up;
      go_float;
      check(sw, 1'b1);
      jo = 1;
      cyc(2);
      check(tsd, 1'b1);
      check(sw, 1'b0);
      jo = 0;
      jc = 1;
      cyc(2);
      check(tsd, 1'b0);
      check(sw, 1'b1);
      jc = 0;
      $display("thermal test done");
    end
  endtask
  task precharge_timeout;
    begin
      power_up;
      wait_st(3'h1);
      te = 1;
      tl = 1;
      cyc(160);
      check(su, 1'b1);
      tl = 0;
      cyc(64);
      check(st, 3'h1);
      wait_st(3'h5);
      check(fbat, 1'b1);
      $display("precharge timeout test done");
    end
  endtask
  task t_faults;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        rn = 0;
        if (i < 4) begin
          power_up;
          {s0, s1, s2, s3} = 4'h8 >> i;
        end else begin
          power_up;
          go_float;
          {fb, rw, gg, dk} = 4'h7 ^ (4'h8 >> (i - 4));
        end
        wait_st(3'h5);
        check(pair, `CODE_FAULT);
        {s0, s1, s2, s3, fb, rw, gg, dk} = 8'h07;
        cyc(5);
        check(st, 3'h5);
        check(gt, 1'b0);
      end
      $display("fault test done");
    end
  endtask
  task t_reg;
    begin
      power_up;
      eh = 1;
      cyc(2);
      check(er, 1'b1);
      eh = 0;
      cyc(2);
      check(er, 1'b1);
      el = 1;
      cyc(2);
      check(er, 1'b0);
      $display("regulator test done");
    end
  endtask
  // Main sequence
  initial begin
    bad_count = 0;
    checks_done = 0;
    t_reg;
    t_temp;
    t_therm;
    precharge_timeout;
    t_faults;
    end_of_test;
  end
endmodule
